// [sbh_pkg.sv]
// Shared constants for the shared-bus slave handshake core
package sbh_pkg;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned PTR_W     = 1;
  localparam int unsigned CNT_W     = 2;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_RST  = 1'h0;
  localparam logic [CNT_W-1:0]  CNT_RST  = 2'h0;
  localparam logic [CNT_W-1:0]  CNT_FULL = 2'h2;
endpackage : sbh_pkg

// [sbh_slave.sv]
// Bus slave: tagged memory with combinatorial terminators and a read buffer
// How it works
// RULE1: Master holds strobe until a terminator.
// RULE2: Master drops strobe after sampled terminator.
// RULE3: Fast slave may tie acknowledge to strobe.
// RULE4: Acknowledge always present, ends cycle normally.
// RULE5: Error ends cycle on parity fault.
// RULE6: Retry ends cycle when resource busy.
// RULE7: Slave has acknowledge, clock and reset.
// RULE8: At most one terminator high at once.
// RULE9: Master strobe and cycle come from flops.
// RULE10: Terminators follow strobe combinatorially.
// RULE11: Interconnect watchdog prevents unused-address deadlock.
// RULE12: Zero-wait single slave may hold acknowledge.
// RULE13: Master tolerates permanently high acknowledge.
// RULE14: Master outputs valid only under strobe.
// RULE15: Cycle frames strobe for whole bus cycle.
// RULE16: Read data valid only with terminator.
// RULE17: Tags follow their tag type's timing.
// RULE18: Write data carries even parity tag.
// RULE19: Master strobe and cycle low through reset.
// RULE20: Respond only under strobe, always terminate.
// RULE21: Write enable low on read, high on write.
// RULE22: Master reports error or retry to core.
`timescale 1ns/1ns
module sbh_slave (
  input  wire logic                      core_clk,   // System clock
  input  wire logic                      rstn,       // Asynchronous reset, active low
  input  wire logic                      clk_en,     // Freezes all state while low
  input  wire logic                      cyc_i,      // Bus cycle in progress
  input  wire logic                      stb_i,      // Slave selected, phase valid
  input  wire logic                      we_i,       // High on write, low on read
  input  wire logic [sbh_pkg::ADDR_W-1:0] adr_i,     // Word address
  input  wire logic [sbh_pkg::DATA_W-1:0] dat_i,     // Write data
  input  wire logic                      tgd_par_i,  // Even parity tag on write data
  output logic                           ack_o,      // Normal termination
  output logic                           err_o,      // Error termination
  output logic                           rty_o,      // Retry termination
  output logic      [sbh_pkg::DATA_W-1:0] dat_o,     // Read data
  output logic                           tgd_par_o,  // Even parity tag on read data
  output logic                           rd_valid,   // Read word stream valid
  input  wire logic                      rd_ready,   // Read word stream ready
  output logic      [sbh_pkg::DATA_W-1:0] rd_data,   // Read word stream data
  output logic                           perr_seen   // Sticky parity fault seen
);

  // Even parity: high when the count of ones is even
  function automatic logic even_par(input logic [sbh_pkg::DATA_W-1:0] d);
    even_par = ~(^d);
  endfunction : even_par

  // Pointers wrap at the buffer depth
  function automatic logic [sbh_pkg::PTR_W-1:0] ptr_inc(
    input logic [sbh_pkg::PTR_W-1:0] p
  );
    ptr_inc = p + 1'b1;
  endfunction : ptr_inc

  // The memory is too large to reset; a word read before it was ever written
  // comes back unknown, so users must write a location before reading it.
  logic [sbh_pkg::DATA_W-1:0] mem_r   [sbh_pkg::MEM_DEPTH];
  logic [sbh_pkg::DATA_W-1:0] buf_r   [sbh_pkg::BUF_DEPTH];
  logic [sbh_pkg::DATA_W-1:0] buf_nxt [sbh_pkg::BUF_DEPTH];
  logic [sbh_pkg::PTR_W-1:0]  wp_r;
  logic [sbh_pkg::PTR_W-1:0]  wp_nxt;
  logic [sbh_pkg::PTR_W-1:0]  rp_r;
  logic [sbh_pkg::PTR_W-1:0]  rp_nxt;
  logic [sbh_pkg::CNT_W-1:0]  cnt_r;
  logic [sbh_pkg::CNT_W-1:0]  cnt_nxt;
  logic                       perr_r;
  logic                       perr_nxt;
  logic                       valid_r;
  logic                       valid_nxt;
  logic [sbh_pkg::DATA_W-1:0] head_r;
  logic [sbh_pkg::DATA_W-1:0] head_nxt;
  logic [sbh_pkg::DATA_W-1:0] rd_word;
  logic                       sel;
  logic                       par_bad;
  logic                       busy;
  logic                       wr_ok;
  logic                       rd_ok;
  logic                       push;
  logic                       pop;

  // Reads answer straight from the memory in the strobe's own cycle, so a
  // master sees data with zero wait states; the same word enters the stream.
  assign rd_word = mem_r[adr_i];
  assign sel     = cyc_i & stb_i;                                   // [RULE20] [RULE15]
  assign par_bad = we_i & (tgd_par_i != even_par(dat_i));           // [RULE5] [RULE17]
  assign busy    = ~we_i & (cnt_r == sbh_pkg::CNT_FULL);            // [RULE6]
  assign wr_ok   = sel & we_i & ~par_bad;                           // [RULE21]
  assign rd_ok   = sel & ~we_i & ~busy;
  // Freezing with the enable also holds off pushes and pops
  assign push    = rd_ok & clk_en;
  assign pop     = valid_r & rd_ready & clk_en;

  // Combinatorial, mutually exclusive terminators; one for every strobe.
  // No wait state is ever inserted, so a tied or held acknowledge fits too.
  always_comb begin
    ack_o     = wr_ok | rd_ok;  // [RULE3] [RULE4] [RULE7] [RULE10] [RULE12]
    err_o     = sel & par_bad;                                      // [RULE5] [RULE10]
    rty_o     = sel & ~par_bad & busy;                              // [RULE6] [RULE8] [RULE20]
    // Data is driven only while a read is acknowledged, zero otherwise
    dat_o     = rd_ok ? rd_word : sbh_pkg::DATA_RST;                // [RULE16]
    tgd_par_o = rd_ok ? even_par(rd_word) : 1'b0;                   // [RULE16] [RULE17]
  end

  // Pointer and occupancy group
  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = ptr_inc(wp_r);
    end
    if (pop) begin
      rp_nxt = ptr_inc(rp_r);
    end
    case ({push, pop})
      2'h2:    cnt_nxt = cnt_r + 2'h1;
      2'h1:    cnt_nxt = cnt_r - 2'h1;
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= sbh_pkg::PTR_RST;
      rp_r  <= sbh_pkg::PTR_RST;
      cnt_r <= sbh_pkg::CNT_RST;
    end else if (clk_en) begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // One storage slot per buffer entry; only the slot under the write pointer
  // takes a push, which keeps the unread word safe while the receiver stalls.
  for (genvar g = 0; g < sbh_pkg::BUF_DEPTH; g++) begin : g_slot
    always_comb begin
      buf_nxt[g] = buf_r[g];
      if (push && (int'(wp_r) == g)) begin
        buf_nxt[g] = rd_word;
      end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        buf_r[g] <= sbh_pkg::DATA_RST;
      end else if (clk_en) begin
        buf_r[g] <= buf_nxt[g];
      end
    end
  end

  // Sticky parity fault: setting wins, only reset clears it
  always_comb begin
    perr_nxt = perr_r;
    if (sel && par_bad) begin
      perr_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      perr_r <= 1'b0;
    end else if (clk_en) begin
      perr_r <= perr_nxt;
    end
  end

  // Registered stream outputs look at the buffer state after this cycle,
  // trading a little logic depth for outputs that come straight from flops.
  always_comb begin
    valid_nxt = (cnt_nxt != sbh_pkg::CNT_RST);
    head_nxt  = buf_nxt[rp_nxt];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      valid_r <= 1'b0;
      head_r  <= sbh_pkg::DATA_RST;
    end else if (clk_en) begin
      valid_r <= valid_nxt;
      head_r  <= head_nxt;
    end
  end

  // Memory has no reset; a write lands at the acknowledged edge
  always_ff @(posedge core_clk) begin
    if (clk_en && wr_ok) begin
      mem_r[adr_i] <= dat_i;
    end
  end

  assign rd_valid  = valid_r;
  assign rd_data   = head_r;
  assign perr_seen = perr_r;

endmodule : sbh_slave

// [sbh_slave_asserts.sv]
// Handshake checker bound to the bus slave
`timescale 1ns/1ns
module sbh_slave_asserts (
  input wire logic core_clk, rstn, clk_en, cyc_i, stb_i, we_i, tgd_par_i,
  input wire logic ack_o, err_o, rty_o, tgd_par_o, perr_seen,
  input wire logic [sbh_pkg::DATA_W-1:0] dat_i, dat_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire ph = cyc_i & stb_i;
  wire ok = tgd_par_i == ~^dat_i;
  AST_EXCL: assert property ($onehot0({ack_o, err_o, rty_o})) else $error("two terms");
  AST_IDLE: assert property (!ph |-> !(ack_o | err_o | rty_o)) else $error("stray term");
  AST_TERM: assert property (ph |-> (ack_o | err_o | rty_o)) else $error("no term");
  AST_WOK: assert property (ph && we_i && ok |-> ack_o) else $error("write not acked");
  AST_WBAD: assert property (ph && we_i && !ok |-> err_o) else $error("fault missed");
  AST_DAT: assert property (!ack_o |-> dat_o == sbh_pkg::DATA_RST) else $error("data");
  AST_RPAR: assert property (ack_o && !we_i |-> tgd_par_o == ~^dat_o) else $error("tag");
  AST_STICK: assert property (err_o && clk_en |=> perr_seen [*2]) else $error("flag");
  AST_RTY: assert property (rty_o |-> !we_i) else $error("retry on write");
endmodule : sbh_slave_asserts
bind sbh_slave sbh_slave_asserts u_chk (.core_clk, .rstn, .clk_en, .cyc_i, .stb_i, .we_i,
  .tgd_par_i, .ack_o, .err_o, .rty_o, .tgd_par_o, .perr_seen, .dat_i, .dat_o);

// [sbh_master_model.sv]
// Bus master model issuing one phase per request
`timescale 1ns/1ns
module sbh_master_model (
  input wire logic core_clk, rstn, go, g_we, g_bad, ack_i, err_i, rty_i,
  input wire logic [7:0] g_adr,
  input wire logic [15:0] g_dat, dat_i,
  output logic cyc_o, stb_o, we_o, par_o, done,
  output logic [7:0] adr_o,
  output logic [15:0] dat_o, rdat,
  output logic [1:0] code
);
  logic [15:0] wd;
  assign cyc_o = stb_o;
  assign dat_o = stb_o ? wd : ~wd; // Released bus shows no stale word
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn) begin stb_o <= 1'h0; done <= 1'h0; end
    else begin
      done <= stb_o & (ack_i | err_i | rty_i);
      if (stb_o && (ack_i | err_i | rty_i)) begin
        stb_o <= 1'h0; rdat <= dat_i; code <= {rty_i, err_i};
      end else if (go && !stb_o) begin
        stb_o <= 1'h1; we_o <= g_we; adr_o <= g_adr; wd <= g_dat;
        par_o <= ~^g_dat ^ g_bad; // Even parity, flipped on demand
      end
    end
endmodule : sbh_master_model

// [tb_soc_bus_handshake_core.sv]
// Self-checking bench for the bus slave
`timescale 1ns/1ns
module tb_soc_bus_handshake_core;
  logic core_clk = 1'h0, rstn = 1'h0, go = 1'h0, g_we = 1'h0, g_bad = 1'h0, rd_ready = 1'h0;
  logic done, cyc, stb, we, par, ack, err, rty, tpar, rd_valid, perr;
  logic [7:0] g_adr = 8'h00, adr;
  logic [15:0] g_dat = 16'h0000, wdat, rdat, dat_o, rd_data;
  logic [1:0] code;
  int n_mismatch, total_checks, s = 78907, mem[int], q[$];
  always #5 core_clk = ~core_clk;
  sbh_master_model u_m (.core_clk, .rstn, .go, .g_we, .g_bad, .g_adr, .g_dat, .ack_i(ack),
    .err_i(err), .rty_i(rty), .dat_i(dat_o), .cyc_o(cyc), .stb_o(stb), .we_o(we), .par_o(par),
    .done, .adr_o(adr), .dat_o(wdat), .rdat, .code);
  sbh_slave dut (.core_clk, .rstn, .clk_en(1'h1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .tgd_par_i(par), .ack_o(ack), .err_o(err), .rty_o(rty), .dat_o,
    .tgd_par_o(tpar), .rd_valid, .rd_ready, .rd_data, .perr_seen(perr));
  function automatic int lfsr(int v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic op(logic w, logic [7:0] a, logic b);
    logic [1:0] ec;
    s = lfsr(s);
    @(posedge core_clk) begin go <= 1'h1; g_we <= w; g_adr <= a; g_bad <= b; g_dat <= s[15:0]; end
    @(posedge core_clk) go <= 1'h0;
    for (int i = 0; i < 20 && done !== 1'h1; i++) @(posedge core_clk) #1;
    chk(done, 1'h1);
    ec = w ? {1'h0, b} : {q.size() == 2, 1'h0}; // Full buffer refuses reads
    chk(code, ec);
    if (w && !b) mem[a] = s[15:0];
    if (!w && ec == 2'h0) begin chk(rdat, mem[a]); q.push_back(mem[a]); end
  endtask : op
  task automatic drain();
    while (q.size() > 0) begin
      chk(rd_valid, 1'h1);
      chk(rd_data, q.pop_front());
      @(posedge core_clk) rd_ready <= 1'h1;
      @(posedge core_clk) rd_ready <= 1'h0;
      #1;
    end
    chk(rd_valid, 1'h0);
  endtask : drain
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin #100000; n_mismatch++; print_verdict(); end
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'h1;
    for (int i = 0; i < 4; i++) op(1'h1, i[7:0], 1'h0);
    op(1'h1, 8'h02, 1'h1);
    chk(perr, 1'h1);
    $display("writes done");
    for (int i = 0; i < 4; i++) op(1'h0, i[7:0], 1'h0);
    drain();
    op(1'h0, 8'h02, 1'h0);
    drain();
    $display("reads done");
    print_verdict();
  end
endmodule : tb_soc_bus_handshake_core
